// ---- logic/apdu_pkg.sv ----
package apdu_pkg;
  // ****************************************
  // inactivity counter
  // ****************************************
  localparam int APDU_CNT_W = 4;
  localparam logic [3:0] APDU_IDLE_LIMIT = 4'hF;
  localparam logic [3:0] APDU_CNT_RESET = 4'h0;
  // ****************************************
  // first power-mode register fields
  // ****************************************
  localparam int APDU_PM0_TURBO_OFF = 3;
  localparam int APDU_PM0_CLK_ARRAY_BLK = 4;
  localparam int APDU_PM0_CLK_MCELL_BLK = 5;
  localparam logic [7:0] APDU_PM0_RESET = 8'h00;
  // ****************************************
  // second power-mode register fields
  // ****************************************
  localparam int APDU_PM2_ADDR_LOW_BLK = 0;
  localparam int APDU_PM2_CNTL0_BLK = 2;
  localparam int APDU_PM2_CNTL1_BLK = 3;
  localparam int APDU_PM2_CNTL2_BLK = 4;
  localparam int APDU_PM2_STROBE_BLK = 5;
  localparam int APDU_PM2_WRH_BLK = 6;
  localparam logic [7:0] APDU_PM2_RESET = 8'h00;
  // ****************************************
  // port functions
  // ****************************************
  typedef enum logic [2:0] {
    APDU_FN_HOST_IO,
    APDU_FN_LOGIC_OUT,
    APDU_FN_ADDR_OUT,
    APDU_FN_DATA_PORT,
    APDU_FN_PERIPH_IO
  } apdu_fn_e;
  typedef enum logic {
    APDU_RUN,
    APDU_DOWN
  } apdu_state_e;
endpackage : apdu_pkg

// ---- logic/apdu_strobe_watch.sv ----
`timescale 1ns/1ps
// ****************************************
// strobe activity detector and idle counter
// ****************************************
module apdu_strobe_watch
  import apdu_pkg::*;
#(
  parameter int CNT_W = APDU_CNT_W
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  input wire logic polarity,
  input wire logic strobe,
  output logic strobe_toggle,
  output logic idle_done
);
  logic strobe_q;
  logic [CNT_W-1:0] count;

  // previous strobe level
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe;
    end
  end

  assign strobe_toggle = strobe ^ strobe_q;

  // idle counter, steady at active level only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= CNT_W'(APDU_CNT_RESET);
    end else if (!enable || strobe_toggle) begin
      count <= CNT_W'(APDU_CNT_RESET);
    end else if (strobe == polarity && count != CNT_W'(APDU_IDLE_LIMIT)) begin
      count <= count + CNT_W'(1);
    end
  end

  assign idle_done = enable && !strobe_toggle && strobe == polarity
    && count == CNT_W'(APDU_IDLE_LIMIT);
endmodule : apdu_strobe_watch

// ---- logic/apdu_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - enabled unit counts idle strobe time
// - fifteen idle clocks raise powerdown flag
// - enabling unit also enables powerdown
// - strobe toggling ends powerdown
// - chip select low or reset wakes
// - powerdown blocks bus, deselects memories
// - memories standby, logic stays active
// - pin behaviour per function in powerdown
// - clock block leaves counter clocked
// - logic clock drives macrocells and counter
// - chip select high disables memories and io registers only
// - set blocking bits gate signals
// - unused signals blocked by configuration
// - turbo bit one means turbo off
// - powerdown leaves logic arrays unchanged
// - count only steady at polarity level
// - turbo control is bit 3
// - bits 4,5 block clock paths
module apdu_top
  import apdu_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16,
  parameter int PINS = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic host_reset,
  input wire logic apd_enable,
  input wire logic strobe_polarity,
  input wire logic host_address_strobe,
  input wire logic chip_select_n,
  input wire logic pm_write_first,
  input wire logic pm_write_second,
  input wire logic [7:0] pm_write_data,
  input wire logic cfg_addr_low_unused,
  input wire logic cfg_cntl_unused,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [DATA_W-1:0] host_data,
  input wire logic [2:0] bus_control_inputs,
  input wire logic high_byte_write_enable,
  input wire logic [PINS-1:0] pin_out_value,
  input wire logic [PINS-1:0] pin_out_enable,
  input wire logic [PINS*3-1:0] pin_function,
  output logic powerdown_flag,
  output logic [7:0] power_mode_reg_first,
  output logic [7:0] power_mode_reg_second,
  output logic memory_select,
  output logic memory_standby,
  output logic io_register_select,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_data,
  output logic [ADDR_W-1:0] array_addr,
  output logic [2:0] array_control,
  output logic array_strobe,
  output logic array_high_byte_we,
  output logic array_clock_enable,
  output logic macrocell_clock_enable,
  output logic turbo_off,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe
);
  apdu_state_e state;
  logic strobe_toggle;
  logic idle_done;
  logic wake;
  logic down;
  logic [ADDR_W-1:0] addr_mask;

  // ****************************************
  // idle watch on the logic clock
  // ****************************************
  // the counter always runs on clock; clock block bits never gate it
  apdu_strobe_watch #(
    .CNT_W(APDU_CNT_W)
  ) u_watch (
    .clock(clock),
    .resetn(resetn),
    .enable(apd_enable),
    .polarity(strobe_polarity),
    .strobe(host_address_strobe),
    .strobe_toggle(strobe_toggle),
    .idle_done(idle_done)
  );

  // ****************************************
  // powerdown state
  // ****************************************
  assign wake = strobe_toggle || !chip_select_n || host_reset;

  // enable alone arms powerdown, nothing else needed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= APDU_RUN;
    end else begin
      unique case (state)
        APDU_RUN: begin
          if (idle_done && !wake) begin
            state <= APDU_DOWN;
          end
        end
        APDU_DOWN: begin
          if (wake || !apd_enable) begin
            state <= APDU_RUN;
          end
        end
      endcase
    end
  end

  assign down = (state == APDU_DOWN);

  // ****************************************
  // power-mode registers
  // ****************************************
  // host writes at run time; cleared only by power-on reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      power_mode_reg_first <= APDU_PM0_RESET;
    end else if (pm_write_first) begin
      power_mode_reg_first <= pm_write_data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      power_mode_reg_second <= APDU_PM2_RESET;
    end else if (pm_write_second) begin
      power_mode_reg_second <= pm_write_data;
    end
  end

  // ****************************************
  // memory side
  // ****************************************
  // chip select high disables memories and io space, not the arrays
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      powerdown_flag <= 1'b0;
      memory_select <= 1'b0;
      memory_standby <= 1'b1;
      io_register_select <= 1'b0;
      mem_addr <= '0;
      mem_data <= '0;
    end else begin
      powerdown_flag <= down;
      memory_select <= !down && !chip_select_n;
      memory_standby <= down || chip_select_n;
      io_register_select <= !down && !chip_select_n;
      if (!down) begin
        mem_addr <= host_addr;
        mem_data <= host_data;
      end
    end
  end

  // ****************************************
  // logic array inputs
  // ****************************************
  assign addr_mask = (power_mode_reg_second[APDU_PM2_ADDR_LOW_BLK] || cfg_addr_low_unused)
    ? {{(ADDR_W-8){1'b1}}, 8'h00} : '1;

  // bus frozen in powerdown, blocking bits hold signals low
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      array_addr <= '0;
      array_control <= 3'h0;
      array_strobe <= 1'b0;
      array_high_byte_we <= 1'b0;
    end else if (!down) begin
      array_addr <= host_addr & addr_mask;
      array_control[0] <= bus_control_inputs[0] && !cfg_cntl_unused
        && !power_mode_reg_second[APDU_PM2_CNTL0_BLK];
      array_control[1] <= bus_control_inputs[1] && !cfg_cntl_unused
        && !power_mode_reg_second[APDU_PM2_CNTL1_BLK];
      array_control[2] <= bus_control_inputs[2] && !cfg_cntl_unused
        && !power_mode_reg_second[APDU_PM2_CNTL2_BLK];
      array_strobe <= host_address_strobe && !cfg_cntl_unused
        && !power_mode_reg_second[APDU_PM2_STROBE_BLK];
      array_high_byte_we <= high_byte_write_enable && !cfg_cntl_unused
        && !power_mode_reg_second[APDU_PM2_WRH_BLK];
    end
  end

  // clock gating and turbo follow the register only, not powerdown
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      array_clock_enable <= 1'b1;
      macrocell_clock_enable <= 1'b1;
      turbo_off <= 1'b0;
    end else begin
      array_clock_enable <= !power_mode_reg_first[APDU_PM0_CLK_ARRAY_BLK];
      macrocell_clock_enable <= !power_mode_reg_first[APDU_PM0_CLK_MCELL_BLK];
      turbo_off <= power_mode_reg_first[APDU_PM0_TURBO_OFF];
    end
  end

  // ****************************************
  // pin behaviour per function
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      apdu_fn_e fn;
      assign fn = apdu_fn_e'(pin_function[gi*3 +: 3]);
      // logic outputs keep running, host io holds; data and peripheral float, address outputs go low
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          pin_out[gi] <= 1'b0;
          pin_oe[gi] <= 1'b0;
        end else if (!down || fn == APDU_FN_LOGIC_OUT) begin
          pin_out[gi] <= pin_out_value[gi];
          pin_oe[gi] <= pin_out_enable[gi];
        end else if (fn == APDU_FN_DATA_PORT || fn == APDU_FN_PERIPH_IO) begin
          pin_oe[gi] <= 1'b0;
        end else if (fn == APDU_FN_ADDR_OUT) begin
          pin_out[gi] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : apdu_top

// ---- testbench/apdu_monitor.sv ----
`timescale 1ns/1ps
// ****************************************
// power-down checker
// ****************************************
module apdu_monitor
  import apdu_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic apd_enable,
  input wire logic strobe_polarity,
  input wire logic host_address_strobe,
  input wire logic chip_select_n,
  input wire logic host_reset,
  input wire logic pm_write_first,
  input wire logic [7:0] pm_write_data,
  input wire logic powerdown_flag,
  input wire logic [7:0] power_mode_reg_first,
  input wire logic memory_select,
  input wire logic memory_standby,
  input wire logic turbo_off,
  input wire logic array_clock_enable,
  input wire logic macrocell_clock_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [4:0] run;
  logic last;
  // reference idle count, cleared by toggle or disable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      run <= 5'h00;
      last <= 1'b0;
    end else begin
      last <= host_address_strobe;
      if (!apd_enable || host_address_strobe != last) run <= 5'h00;
      else if (host_address_strobe == strobe_polarity && run != 5'h1F) run <= run + 5'h01;
    end
  end
  sequence no_wake;
    (chip_select_n && !host_reset && apd_enable) [*3];
  endsequence
  sequence toggled;
    host_address_strobe != $past(host_address_strobe);
  endsequence
  idle_entry_a: assert property ((no_wake ##0 run >= 5'h11) |-> powerdown_flag)
    else $error("flag missing after idle run");
  early_entry_a: assert property (run inside {[1:15]} |-> !powerdown_flag)
    else $error("flag before fifteen idle clocks");
  strobe_wake_a: assert property (toggled |-> ##3 !powerdown_flag)
    else $error("strobe activity did not wake");
  select_wake_a: assert property (!chip_select_n [*2] |-> ##1 !powerdown_flag)
    else $error("chip select did not wake");
  reset_wake_a: assert property (host_reset [*2] |-> ##1 !powerdown_flag)
    else $error("host reset did not wake");
  enable_off_a: assert property (!apd_enable [*2] |-> ##1 !powerdown_flag)
    else $error("flag with unit disabled");
  mem_block_a: assert property (powerdown_flag |-> !memory_select && memory_standby)
    else $error("memories active in power-down");
  cs_standby_a: assert property (chip_select_n [*2] |-> memory_standby)
    else $error("memories active while deselected");
  reg_write_a: assert property (pm_write_first |=> power_mode_reg_first == $past(pm_write_data))
    else $error("first register write lost");
  turbo_bit_a: assert property ($stable(power_mode_reg_first) |->
    turbo_off == power_mode_reg_first[APDU_PM0_TURBO_OFF])
    else $error("turbo output wrong");
  clock_block_a: assert property ($stable(power_mode_reg_first) |->
    array_clock_enable != power_mode_reg_first[APDU_PM0_CLK_ARRAY_BLK] &&
    macrocell_clock_enable != power_mode_reg_first[APDU_PM0_CLK_MCELL_BLK])
    else $error("clock enables wrong");
endmodule : apdu_monitor
bind apdu_top apdu_monitor u_apdu_monitor (.clock, .resetn, .apd_enable, .strobe_polarity,
  .host_address_strobe, .chip_select_n, .host_reset, .pm_write_first, .pm_write_data,
  .powerdown_flag, .power_mode_reg_first, .memory_select, .memory_standby, .turbo_off,
  .array_clock_enable, .macrocell_clock_enable);

// ---- testbench/apdu_host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// host bus model
// ****************************************
module apdu_host_model (
  input wire logic clock,
  input wire logic pulse,
  input wire logic park,
  output logic host_address_strobe = 1'b0,
  output logic [15:0] host_addr = 16'h1234,
  output logic [15:0] host_data = 16'h5AA5
);
  // strobe toggles while busy, rests at park level; bus keeps moving
  always @(posedge clock) begin
    host_address_strobe <= #1 pulse ? !host_address_strobe : park;
    host_addr <= #1 host_addr + 16'h0101;
    host_data <= #1 ~host_data;
  end
endmodule : apdu_host_model

// ---- testbench/auto_power_down_unit_test.sv ----
`timescale 1ns/1ps
// ****************************************
// power-down unit bench
// ****************************************
module auto_power_down_unit_test;
  logic clock = 1'b0, resetn = 1'b0, host_reset = 1'b0, apd_enable = 1'b1, pulse = 1'b1;
  logic chip_select_n = 1'b1, pm_write_first = 1'b0, pm_write_second = 1'b0, park = 1'b1;
  logic cfg_addr_low_unused = 1'b0, cfg_cntl_unused = 1'b0, strobe_polarity = 1'b1;
  logic [7:0] pm_write_data = 8'h00;
  logic powerdown_flag, memory_select, memory_standby, array_strobe, turbo_off;
  logic array_clock_enable, macrocell_clock_enable, host_address_strobe;
  logic [7:0] power_mode_reg_first, power_mode_reg_second;
  logic [15:0] host_addr, host_data, array_addr, mem_addr, mem_data;
  logic [7:0] pin_value = 8'hA5, pin_out, pin_oe;
  logic [2:0] array_control;
  logic io_register_select, array_high_byte_we;
  logic [31:0] frozen;
  int mismatches = 0;
  int num_checks = 0;
  always #5 clock = ~clock;
  apdu_host_model u_apdu_host_model (.clock, .pulse, .park, .host_address_strobe, .host_addr,
    .host_data);
  // pin 1 logic out, 2 address out, 3 data port, 4 peripheral, rest host io
  apdu_top u_apdu_top (.clock, .resetn, .host_reset, .apd_enable, .strobe_polarity,
    .host_address_strobe, .chip_select_n, .pm_write_first, .pm_write_second, .pm_write_data,
    .cfg_addr_low_unused, .cfg_cntl_unused, .host_addr, .host_data,
    .bus_control_inputs(3'h7), .high_byte_write_enable(1'b1), .pin_out_value(pin_value),
    .pin_out_enable(8'hFF), .pin_function(24'h004688), .powerdown_flag,
    .power_mode_reg_first, .power_mode_reg_second, .memory_select, .memory_standby,
    .io_register_select, .mem_addr, .mem_data, .array_addr, .array_control,
    .array_strobe, .array_high_byte_we, .array_clock_enable, .macrocell_clock_enable,
    .turbo_off, .pin_out, .pin_oe);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  // one-cycle write of a power-mode register
  task automatic wr(input logic sel, input logic [7:0] d);
    pm_write_data = d;
    pm_write_first = !sel;
    pm_write_second = sel;
    step(1);
    pm_write_first = 1'b0;
    pm_write_second = 1'b0;
  endtask : wr
  // stop the strobe at the counting level and wait out the idle count
  task automatic sleep(input logic pol);
    strobe_polarity = pol;
    park = pol;
    pulse = 1'b0;
    step(14);
    chk(powerdown_flag, 1'b0);
    step(6);
    chk({powerdown_flag, memory_select, memory_standby, io_register_select}, 4'hA);
  endtask : sleep
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
  // main sequence
  initial begin
    step(3);
    resetn = 1'b1;
    step(2);
    chk(power_mode_reg_first, 8'h00);
    chk(turbo_off, 1'b0);
    wr(1'b0, 8'h38);
    step(1);
    chk(power_mode_reg_first, 8'h38);
    chk({turbo_off, array_clock_enable, macrocell_clock_enable}, 3'b100);
    sleep(1'b1);
    // memory bus must stay frozen while the host bus keeps moving
    frozen = {mem_addr, mem_data};
    pin_value = 8'h5A;
    step(1);
    chk({mem_addr, mem_data}, frozen);
    step(1);
    chk({pin_out, pin_oe}, 16'hA3E7);
    pulse = 1'b1;
    step(3);
    chk(powerdown_flag, 1'b0);
    chk({pin_out, pin_oe}, 16'h5AFF);
    sleep(1'b0);
    chip_select_n = 1'b0;
    step(3);
    chk({powerdown_flag, memory_select, io_register_select}, 3'b011);
    chip_select_n = 1'b1;
    pulse = 1'b1;
    step(2);
    sleep(1'b1);
    host_reset = 1'b1;
    step(3);
    chk({powerdown_flag, power_mode_reg_first}, 9'h038);
    host_reset = 1'b0;
    pulse = 1'b1;
    step(2);
    apd_enable = 1'b0;
    pulse = 1'b0;
    step(25);
    chk(powerdown_flag, 1'b0);
    apd_enable = 1'b1;
    pulse = 1'b1;
    step(2);
    park = 1'b0;
    pulse = 1'b0;
    step(25);
    chk({powerdown_flag, memory_select, memory_standby}, 3'b001);
    wr(1'b1, 8'h20);
    cfg_addr_low_unused = 1'b1;
    pulse = 1'b1;
    step(2);
    chk({power_mode_reg_second, array_strobe, array_addr[7:0]}, 17'h04000);
    chk({array_control, array_high_byte_we}, 4'hF);
    wr(1'b1, 8'h5C);
    step(1);
    chk({array_control, array_high_byte_we, array_strobe}, 5'h01);
    cfg_cntl_unused = 1'b1;
    wr(1'b1, 8'h00);
    step(1);
    chk({array_control, array_high_byte_we, array_strobe}, 5'h00);
    end_of_test();
  end
endmodule : auto_power_down_unit_test
